// File: logic/debug_control_regs.vh
// Purpose: Constants for the debug control register bank
// Assumes: One 32-bit word at offset 0x0 of the debug register segment
// Notes:   Field positions, reset values and sampling counts
`ifndef DEBUG_CONTROL_REGS_VH
`define DEBUG_CONTROL_REGS_VH

`define DEBUG_CONTROL_OFFSET      32'h0000_0000
`define BIT_SECURE_OVERRIDE       31
`define BIT_ENDIAN                29
`define BIT_MISS_ONLY             26
`define BIT_OMIT_SPACE_ID         25
`define BIT_DATA_SAMPLE_QUAL      24
`define BIT_DATA_SAMPLE_EN        23
`define BIT_DATA_SAMPLE_PRES      22
`define BIT_FAST_CHANNEL          18
`define BIT_DATA_BREAK            17
`define BIT_FETCH_BREAK           16
`define BIT_INVERTED_MATCH        15
`define BIT_VALUE_STORE           14
`define BIT_VECTOR_RELOCATE       11
`define BIT_COMPLEX_BREAK         10
`define BIT_SAMPLING_PRESENT      9
`define RATE_HI                   8
`define RATE_LO                   6
`define BIT_SAMPLING_ENABLE       5
`define BIT_INTERRUPT_GATE        4
`define BIT_NMI_GATE              3
`define BIT_NMI_WAITING           2
`define BIT_SOFT_RESET_GATE       1
`define BIT_PROBE_SERVICE         0

`define RST_INTERRUPT_GATE        1'b1
`define RST_NMI_GATE              1'b1
`define RST_SOFT_RESET_GATE       1'b1
`define RST_SAMPLING_RATE         3'h7
`define RST_SAMPLING_ENABLE       1'b0
`define RST_VECTOR_RELOCATE       1'b0
`define RST_SECURE_OVERRIDE       1'b0
`define SAMPLE_BASE_LOG2          5
`define SAMPLE_CNT_W              12

`endif

// File: logic/sample_timer.v
// Purpose: Program counter sample period timer
// Assumes: Rate code selects 2**(5+rate) cycles
// Notes:   Counter held clear while disabled
`timescale 1ns/10ps
`include "debug_control_regs.vh"
module sample_timer (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       soft_rst,
   input  wire       enable,
   input  wire [2:0] rate,
   output reg        sample_tick_ff
);
   reg  [`SAMPLE_CNT_W-1:0] count_ff;
   wire [`SAMPLE_CNT_W:0]   span;
   wire [`SAMPLE_CNT_W:0]   span_m1;
   wire [`SAMPLE_CNT_W-1:0] last;
   reg  [`SAMPLE_CNT_W-1:0] nxt_count;
   reg                      nxt_tick;

   // Terminal value 2**(5+rate)-1; shift amount kept 4 bits wide
   assign span    = {{`SAMPLE_CNT_W{1'b0}}, 1'b1} << ({1'b0, rate} + 4'h5);
   assign span_m1 = span - {{`SAMPLE_CNT_W{1'b0}}, 1'b1};
   assign last    = span_m1[`SAMPLE_CNT_W-1:0];

   always @* begin
      nxt_count = 12'h000;
      nxt_tick  = 1'b0;
      if (enable) begin
         if (count_ff >= last) begin
            nxt_tick  = 1'b1;
         end else begin
            nxt_count = count_ff + 12'h001;
         end
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_ff       <= 12'h000;
         sample_tick_ff <= 1'b0;
      end else if (soft_rst) begin
         count_ff       <= 12'h000;
         sample_tick_ff <= 1'b0;
      end else begin
         count_ff       <= nxt_count;
         sample_tick_ff <= nxt_tick;
      end
   end
endmodule

// File: logic/debug_control.v
// Purpose: Debug control and capability register of the on-chip debug unit
// Assumes: Simple word access port from the debug segment decoder
// Notes:   Hard reset arst_n, soft reset soft_rst both load reset values
//
// How it works
// - Register sits at debug segment offset zero
// - Cleared interrupt gate blocks interrupts outside debug
// - Cleared NMI gate blocks NMI outside debug
// - Read-only flag shows NMI pending
// - Soft reset gate driven out, not used internally
// - Probe service bit mirrors test-port probe enable
// - Zero mirror forbids debug memory segment accesses
// - Hard and soft reset load reset values
// - Endian indicator read from external setting
// - Miss-only sampling selector reads zero
// - Space identifier omission bit reads zero
// - Data address sampling bits read zero
// - Fast channel presence reads one
// - Preset data and fetch breakpoint presence
// - Preset inverted match and value store
// - Relocate bit selects programmable vector without trap
// - Preset complex breakpoint presence bit
// - Sampling presence reads one
// - Rate field picks 2**(5+value) cycle period
// - Sampling enable starts sample counters
// - Secure override re-enables break request when built
// - Unused bits read zero
`timescale 1ns/10ps
`include "debug_control_regs.vh"
module debug_control #(
   parameter DATA_BREAK_PRESENT     = 1'b1,
   parameter FETCH_BREAK_PRESENT    = 1'b1,
   parameter INVERTED_MATCH_PRESENT = 1'b0,
   parameter VALUE_STORE_PRESENT    = 1'b0,
   parameter COMPLEX_BREAK_PRESENT  = 1'b0,
   parameter SECURE_DEBUG_PRESENT   = 1'b1
) (
   input  wire        sys_clk,
   input  wire        arst_n,
   input  wire        soft_rst,
   input  wire        reg_sel,
   input  wire [31:0] reg_addr,
   input  wire        reg_wr,
   input  wire [31:0] reg_wdata,
   output reg  [31:0] reg_rdata_ff,
   input  wire        debug_mode,
   input  wire        endian_indicator,
   input  wire        nmi_raw,
   input  wire        int_raw,
   input  wire        probe_enable,
   input  wire        probe_trap,
   input  wire        probe_break_request,
   input  wire        debug_interrupt_pin,
   input  wire        boot_break_block,
   output wire        int_allowed,
   output wire        nmi_allowed,
   output wire        soft_reset_gate_out,
   output wire        dmseg_allowed,
   output wire        use_debug_vector_base,
   output wire        debug_break_req,
   output wire        sample_tick
);
   reg         rst_meta_ff;
   reg         rst_sync_ff;
   reg         interrupt_gate_ff;
   reg         nmi_gate_ff;
   reg         soft_reset_gate_ff;
   reg  [2:0]  sampling_rate_ff;
   reg         sampling_enable_ff;
   reg         vector_relocate_ff;
   reg         secure_break_override_ff;
   reg         nmi_waiting_ff;
   reg         probe_service_mirror_ff;
   reg         nxt_interrupt_gate;
   reg         nxt_nmi_gate;
   reg         nxt_soft_reset_gate;
   reg  [2:0]  nxt_sampling_rate;
   reg         nxt_sampling_enable;
   reg         nxt_vector_relocate;
   reg         nxt_secure_break_override;
   reg         nxt_nmi_waiting;
   reg         nxt_probe_service_mirror;
   wire        rst_n;
   wire        hit;
   wire        wr_hit;
   reg  [31:0] rd_word;

   // Reset release synchroniser
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   assign hit    = reg_sel && (reg_addr == `DEBUG_CONTROL_OFFSET);
   assign wr_hit = hit && reg_wr;

   // Interrupt gate; read-only fields never take write data
   always @* begin
      nxt_interrupt_gate = interrupt_gate_ff;
      if (soft_rst) begin
         nxt_interrupt_gate = `RST_INTERRUPT_GATE;
      end else if (wr_hit) begin
         nxt_interrupt_gate = reg_wdata[`BIT_INTERRUPT_GATE];
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_gate_ff <= `RST_INTERRUPT_GATE;
      end else begin
         interrupt_gate_ff <= nxt_interrupt_gate;
      end
   end

   // NMI gate
   always @* begin
      nxt_nmi_gate = nmi_gate_ff;
      if (soft_rst) begin
         nxt_nmi_gate = `RST_NMI_GATE;
      end else if (wr_hit) begin
         nxt_nmi_gate = reg_wdata[`BIT_NMI_GATE];
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nmi_gate_ff <= `RST_NMI_GATE;
      end else begin
         nmi_gate_ff <= nxt_nmi_gate;
      end
   end

   // Soft reset gate
   always @* begin
      nxt_soft_reset_gate = soft_reset_gate_ff;
      if (soft_rst) begin
         nxt_soft_reset_gate = `RST_SOFT_RESET_GATE;
      end else if (wr_hit) begin
         nxt_soft_reset_gate = reg_wdata[`BIT_SOFT_RESET_GATE];
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         soft_reset_gate_ff <= `RST_SOFT_RESET_GATE;
      end else begin
         soft_reset_gate_ff <= nxt_soft_reset_gate;
      end
   end

   // Sampling rate
   always @* begin
      nxt_sampling_rate = sampling_rate_ff;
      if (soft_rst) begin
         nxt_sampling_rate = `RST_SAMPLING_RATE;
      end else if (wr_hit) begin
         nxt_sampling_rate = reg_wdata[`RATE_HI:`RATE_LO];
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sampling_rate_ff <= `RST_SAMPLING_RATE;
      end else begin
         sampling_rate_ff <= nxt_sampling_rate;
      end
   end

   // Sampling enable
   always @* begin
      nxt_sampling_enable = sampling_enable_ff;
      if (soft_rst) begin
         nxt_sampling_enable = `RST_SAMPLING_ENABLE;
      end else if (wr_hit) begin
         nxt_sampling_enable = reg_wdata[`BIT_SAMPLING_ENABLE];
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sampling_enable_ff <= `RST_SAMPLING_ENABLE;
      end else begin
         sampling_enable_ff <= nxt_sampling_enable;
      end
   end

   // Vector relocation
   always @* begin
      nxt_vector_relocate = vector_relocate_ff;
      if (soft_rst) begin
         nxt_vector_relocate = `RST_VECTOR_RELOCATE;
      end else if (wr_hit) begin
         nxt_vector_relocate = reg_wdata[`BIT_VECTOR_RELOCATE];
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         vector_relocate_ff <= `RST_VECTOR_RELOCATE;
      end else begin
         vector_relocate_ff <= nxt_vector_relocate;
      end
   end

   // Secure override, stuck at zero when not built
   always @* begin
      nxt_secure_break_override = secure_break_override_ff;
      if (soft_rst) begin
         nxt_secure_break_override = `RST_SECURE_OVERRIDE;
      end else if (wr_hit) begin
         nxt_secure_break_override = reg_wdata[`BIT_SECURE_OVERRIDE] & SECURE_DEBUG_PRESENT;
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         secure_break_override_ff <= `RST_SECURE_OVERRIDE;
      end else begin
         secure_break_override_ff <= nxt_secure_break_override;
      end
   end

   // Pending NMI capture
   always @* begin
      nxt_nmi_waiting = nmi_raw;
      if (soft_rst) begin
         nxt_nmi_waiting = 1'b0;
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         nmi_waiting_ff <= 1'b0;
      end else begin
         nmi_waiting_ff <= nxt_nmi_waiting;
      end
   end

   // Probe enable mirror
   always @* begin
      nxt_probe_service_mirror = probe_enable;
      if (soft_rst) begin
         nxt_probe_service_mirror = 1'b0;
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         probe_service_mirror_ff <= 1'b0;
      end else begin
         probe_service_mirror_ff <= nxt_probe_service_mirror;
      end
   end

   // Read word assembly
   always @* begin
      rd_word = 32'h0000_0000;
      rd_word[`BIT_SECURE_OVERRIDE]  = secure_break_override_ff;
      rd_word[`BIT_ENDIAN]           = endian_indicator;
      rd_word[`BIT_MISS_ONLY]        = 1'b0;
      rd_word[`BIT_OMIT_SPACE_ID]    = 1'b0;
      rd_word[`BIT_DATA_SAMPLE_QUAL] = 1'b0;
      rd_word[`BIT_DATA_SAMPLE_EN]   = 1'b0;
      rd_word[`BIT_DATA_SAMPLE_PRES] = 1'b0;
      rd_word[`BIT_FAST_CHANNEL]     = 1'b1;
      rd_word[`BIT_DATA_BREAK]       = DATA_BREAK_PRESENT;
      rd_word[`BIT_FETCH_BREAK]      = FETCH_BREAK_PRESENT;
      rd_word[`BIT_INVERTED_MATCH]   = INVERTED_MATCH_PRESENT;
      rd_word[`BIT_VALUE_STORE]      = VALUE_STORE_PRESENT;
      rd_word[`BIT_VECTOR_RELOCATE]  = vector_relocate_ff;
      rd_word[`BIT_COMPLEX_BREAK]    = COMPLEX_BREAK_PRESENT;
      rd_word[`BIT_SAMPLING_PRESENT] = 1'b1;
      rd_word[`RATE_HI:`RATE_LO]     = sampling_rate_ff;
      rd_word[`BIT_SAMPLING_ENABLE]  = sampling_enable_ff;
      rd_word[`BIT_INTERRUPT_GATE]   = interrupt_gate_ff;
      rd_word[`BIT_NMI_GATE]         = nmi_gate_ff;
      rd_word[`BIT_NMI_WAITING]      = nmi_waiting_ff;
      rd_word[`BIT_SOFT_RESET_GATE]  = soft_reset_gate_ff;
      rd_word[`BIT_PROBE_SERVICE]    = probe_service_mirror_ff;
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= 32'h0000_0000;
      end else if (hit && !reg_wr) begin
         reg_rdata_ff <= rd_word;
      end else begin
         reg_rdata_ff <= 32'h0000_0000;
      end
   end

   assign int_allowed = int_raw && (debug_mode || interrupt_gate_ff);
   assign nmi_allowed = nmi_raw && (debug_mode || nmi_gate_ff);
   assign soft_reset_gate_out = soft_reset_gate_ff;
   assign dmseg_allowed = probe_service_mirror_ff;
   assign use_debug_vector_base = vector_relocate_ff && !probe_trap;
   assign debug_break_req = (probe_break_request || debug_interrupt_pin)
                            && (!boot_break_block || secure_break_override_ff);

   sample_timer u_sample_timer (
      .sys_clk        (sys_clk),
      .rst_n          (rst_n),
      .soft_rst       (soft_rst),
      .enable         (sampling_enable_ff),
      .rate           (sampling_rate_ff),
      .sample_tick_ff (sample_tick)
   );
endmodule

// File: testbench/debug_control_props.sv
// Purpose: Port checks for debug_control
// Assumes: Shadow of writable gate, relocate and override bits
// Notes:   Bound below
`timescale 1ns/10ps
module debug_control_props (
   input wire        sys_clk,
   input wire        arst_n,
   input wire        soft_rst,
   input wire        reg_sel,
   input wire [31:0] reg_addr,
   input wire        reg_wr,
   input wire [31:0] reg_wdata,
   input wire [31:0] reg_rdata_ff,
   input wire        debug_mode,
   input wire        nmi_raw,
   input wire        int_raw,
   input wire        probe_enable,
   input wire        probe_trap,
   input wire        probe_break_request,
   input wire        debug_interrupt_pin,
   input wire        boot_break_block,
   input wire        int_allowed,
   input wire        nmi_allowed,
   input wire        soft_reset_gate_out,
   input wire        dmseg_allowed,
   input wire        use_debug_vector_base,
   input wire        debug_break_req,
   input wire        sample_tick
);
   reg [4:0] sh_ff;
   reg [1:0] live_ff;
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sh_ff <= 5'h07;
         live_ff <= 2'h0;
      end else begin
         if (live_ff != 2'h3)
            live_ff <= live_ff + 2'h1;
         if (soft_rst)
            sh_ff <= 5'h07;
         else if (reg_sel && reg_wr && reg_addr == 32'h0)
            sh_ff <= {reg_wdata[31], reg_wdata[11], reg_wdata[4:3], reg_wdata[1]};
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   sequence rd_hit;
      reg_sel && !reg_wr && reg_addr == 32'h0;
   endsequence
   int_gate_a: assert property (int_allowed == (int_raw && (debug_mode || sh_ff[2])))
      else $error("int gate");
   nmi_gate_a: assert property (nmi_allowed == (nmi_raw && (debug_mode || sh_ff[1])))
      else $error("nmi gate");
   soft_gate_a: assert property (soft_reset_gate_out == sh_ff[0])
      else $error("soft gate");
   vec_reloc_a: assert property (use_debug_vector_base == (sh_ff[3] && !probe_trap))
      else $error("vector");
   break_ovr_a: assert property (debug_break_req ==
      ((probe_break_request || debug_interrupt_pin) && (!boot_break_block || sh_ff[4])))
      else $error("break");
   probe_mirror_a: assert property (live_ff == 2'h3 |-> dmseg_allowed ==
      ($past(probe_enable) && !$past(soft_rst)))
      else $error("mirror");
   rd_zero_a: assert property (rd_hit |=> (reg_rdata_ff & 32'h5ff83000) == 32'h0)
      else $error("zero bits");
   rd_ones_a: assert property (rd_hit |=> (reg_rdata_ff & 32'h00040200) == 32'h00040200)
      else $error("one bits");
   rd_idle_a: assert property (!(reg_sel && !reg_wr && reg_addr == 32'h0) |=>
      reg_rdata_ff == 32'h0)
      else $error("idle data");
   tick_pulse_a: assert property (sample_tick |=> !sample_tick [*8])
      else $error("tick");
endmodule
bind debug_control debug_control_props i_debug_control_props (.*);

// File: testbench/probe_model.sv
// Purpose: Probe side lines
// Assumes: Bench command
// Notes:   Lines change at falling edge
`timescale 1ns/10ps
module probe_model (
   input  wire       sys_clk,
   input  wire [2:0] cmd,
   output reg        probe_enable,
   output reg        probe_trap,
   output reg        probe_break_request
);
   initial {probe_enable, probe_trap, probe_break_request} = 3'h0;
   always @(negedge sys_clk) begin
      {probe_enable, probe_trap, probe_break_request} <= cmd;
   end
endmodule

// File: testbench/debug_control_test.sv
// Purpose: Self-checking bench
// Assumes: Inputs change at falling edge; t_write drops debug_mode and nmi_raw 1 ns after one
// Notes:   Probe lines from probe_model
`timescale 1ns/10ps
module debug_control_test;
   reg         sys_clk, arst_n, soft_rst, reg_sel, reg_wr, debug_mode;
   reg         endian_indicator, nmi_raw, int_raw, boot_break_block, debug_interrupt_pin;
   reg  [31:0] reg_addr, reg_wdata;
   reg  [2:0]  probe_cmd;
   wire [31:0] reg_rdata_ff;
   wire        int_allowed, nmi_allowed, soft_reset_gate_out, dmseg_allowed;
   wire        use_debug_vector_base, debug_break_req, sample_tick;
   wire        probe_enable, probe_trap, probe_break_request;
   integer     fails, compares, n, r;
   debug_control i_debug_control (.sys_clk(sys_clk), .arst_n(arst_n), .soft_rst(soft_rst),
      .reg_sel(reg_sel), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata_ff(reg_rdata_ff), .debug_mode(debug_mode), .endian_indicator(endian_indicator),
      .nmi_raw(nmi_raw), .int_raw(int_raw), .probe_enable(probe_enable),
      .probe_trap(probe_trap), .probe_break_request(probe_break_request),
      .debug_interrupt_pin(debug_interrupt_pin), .boot_break_block(boot_break_block),
      .int_allowed(int_allowed), .nmi_allowed(nmi_allowed),
      .soft_reset_gate_out(soft_reset_gate_out), .dmseg_allowed(dmseg_allowed),
      .use_debug_vector_base(use_debug_vector_base), .debug_break_req(debug_break_req),
      .sample_tick(sample_tick));
   probe_model i_probe_model (.sys_clk(sys_clk), .cmd(probe_cmd), .probe_enable(probe_enable),
      .probe_trap(probe_trap), .probe_break_request(probe_break_request));
   task check(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task access(input w, input [31:0] a, input [31:0] d);
      begin
         @(negedge sys_clk);
         reg_sel = 1'b1;
         reg_wr = w;
         reg_addr = a;
         reg_wdata = d;
         @(negedge sys_clk);
         reg_sel = 1'b0;
      end
   endtask
   task rd(input [31:0] a, input [31:0] exp);
      begin
         access(1'b0, a, 32'h0);
         check(reg_rdata_ff, exp);
      end
   endtask
   task wait_tick;
      begin
         n = 0;
         do begin
            @(negedge sys_clk);
            n = n + 1;
         end while (sample_tick !== 1'b1 && n < 9000);
      end
   endtask
   task t_write;
      begin
         rd(32'h0, 32'h000703da);
         access(1'b1, 32'h0, 32'ha7c7cfff);
         rd(32'h0, 32'h80070bfa);
         access(1'b1, 32'h0, 32'h0);
         int_raw = 1'b1;
         nmi_raw = 1'b1;
         rd(32'h0, 32'h00070204);
         check({int_allowed, nmi_allowed, soft_reset_gate_out}, 32'h0);
         debug_mode = 1'b1;
         #1 check({int_allowed, nmi_allowed}, 32'h3);
         debug_mode = 1'b0;
         nmi_raw = 1'b0;
         rd(32'h4, 32'h0);
         @(negedge sys_clk);
         soft_rst = 1'b1;
         @(negedge sys_clk);
         soft_rst = 1'b0;
         rd(32'h0, 32'h000703da);
      end
   endtask
   task t_probe;
      begin
         probe_cmd = 3'h5;
         endian_indicator = 1'b1;
         boot_break_block = 1'b1;
         repeat (2) @(negedge sys_clk);
         check({debug_break_req, use_debug_vector_base}, 32'h0);
         rd(32'h0, 32'h200703db);
         check({31'h0, dmseg_allowed}, 32'h1);
         access(1'b1, 32'h0, 32'h800009d8);
         check({debug_break_req, use_debug_vector_base}, 32'h3);
         probe_cmd = 3'h6;
         debug_interrupt_pin = 1'b1;
         repeat (2) @(negedge sys_clk);
         check({debug_break_req, use_debug_vector_base}, 32'h2);
      end
   endtask
   task t_sample;
      begin
         for (r = 0; r < 8; r = r + 1) begin
            access(1'b1, 32'h0, 32'h00000038 | (r << 6));
            wait_tick;
            wait_tick;
            check(n, 32'h20 << r);
         end
         access(1'b1, 32'h0, 32'h0);
         wait_tick;
         check(n, 9000);
      end
   endtask
   task report_and_stop;
      begin
         if (fails == 0 && compares > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      #600000;
      fails = fails + 1;
      report_and_stop;
   end
   initial begin
      {fails, compares, arst_n, soft_rst, reg_sel, reg_wr, debug_mode} = 0;
      {endian_indicator, nmi_raw, int_raw, boot_break_block, debug_interrupt_pin} = 5'h0;
      {reg_addr, reg_wdata, probe_cmd} = 0;
      repeat (10) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (3) @(negedge sys_clk);
      t_write;
      t_probe;
      t_sample;
      report_and_stop;
   end
endmodule
